/* File: smsc_ctrl.sv */
// What this block does
// [R1] far side holds smi low four clocks
// [R2] smi wins over pending nmi
// [R3] drive smi low throughout service routine
// [R4] smi ignored until enable bit set
// [R5] finish instruction and cycles before suspend
// [R6] wait coprocessor not busy before suspend
// [R7] suspend ack low on request or halt
// [R8] write/read low on read cycles
// [R9] write/read high on writes, three-state
// [R10] mgmt strobe replaces address strobe in smm
// [R11] release suspend when request negated
`timescale 1ns/1ps
`default_nettype none
`include "smsc_map.svh"
module smsc_ctrl (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // configuration
  input  wire logic cfg_wr_in,
  input  wire logic mgmt_enable_bit_in,
  // management interrupt pin
  input  wire logic system_mgmt_interrupt_n_in,
  output logic      system_mgmt_interrupt_n_out,
  output logic      system_mgmt_interrupt_n_oe_out,
  // non-maskable interrupt, smi take and smm exit
  input  wire logic nmi_req_in,
  output logic      nmi_take_out,
  output logic      smi_take_out,
  input  wire logic smm_exit_in,
  // core status
  input  wire logic core_idle_in,
  input  wire logic halt_in,
  input  wire logic coproc_busy_n_in,
  // suspend
  input  wire logic suspend_request_n_in,
  output logic      suspend_ack_n_out,
  output logic      suspend_ack_n_oe_out,
  output logic      exec_stall_out,
  // bus cycle
  input  wire logic cyc_start_in,
  input  wire logic cyc_write_in,
  input  wire logic bus_float_in,
  output logic      address_strobe_n_out,
  output logic      mgmt_address_strobe_n_out,
  output logic      mgmt_address_strobe_n_oe_out,
  output logic      write_read_out,
  output logic      write_read_oe_out
);
  smsc_pkg::smsc_regs_t r_q;
  smsc_pkg::smsc_regs_t r_d;
  logic smi_seen;

  // ==========================================
  // low level qualifier
  smsc_low_filter #(.COUNT(`SMSC_SMI_LOW_CLKS)) u_filt (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .level_n_in  (system_mgmt_interrupt_n_in || r_q.smi_drive),
    .seen_out    (smi_seen)
  );

  logic smi_req;
  assign smi_req = smi_seen && r_q.mgmt_en; // [R1] [R4]

  // ==========================================
  // next state
  always_comb begin
    r_d = r_q;
    smi_take_out = 1'b0;
    nmi_take_out = 1'b0;
    if (cfg_wr_in) begin
      r_d.mgmt_en = mgmt_enable_bit_in; // [R4]
    end
    case (r_q.st)
      smsc_pkg::SMSC_RUN: begin
        if (smi_req) begin
          r_d.st = smsc_pkg::SMSC_SMM; // [R2]
          r_d.smi_drive = 1'b1; // [R3]
          smi_take_out = 1'b1;
        end else if (r_q.nmi_pend) begin
          r_d.nmi_pend = 1'b0;
          nmi_take_out = 1'b1;
        end else if (!suspend_request_n_in || halt_in) begin
          r_d.st = smsc_pkg::SMSC_DRAIN; // [R5]
        end
      end
      smsc_pkg::SMSC_DRAIN: begin
        if (core_idle_in) begin
          r_d.st = smsc_pkg::SMSC_WAITCP; // [R5]
        end
      end
      smsc_pkg::SMSC_WAITCP: begin
        if (coproc_busy_n_in) begin
          r_d.st = smsc_pkg::SMSC_SUSPEND_REQUEST_N; // [R6]
          r_d.suspend_request_n_ack = 1'b1; // [R7]
        end
      end
      smsc_pkg::SMSC_SUSPEND_REQUEST_N: begin
        if (suspend_request_n_in && !halt_in) begin
          r_d.st = smsc_pkg::SMSC_RUN; // [R11]
          r_d.suspend_request_n_ack = 1'b0;
        end
      end
      smsc_pkg::SMSC_SMM: begin
        if (smm_exit_in) begin
          r_d.st = smsc_pkg::SMSC_RUN;
          r_d.smi_drive = 1'b0; // [R3]
        end
      end
      default: begin
        r_d.st = smsc_pkg::SMSC_RUN;
      end
    endcase
    // a new nmi event wins over the clear of the pending flag
    if (nmi_req_in) begin
      r_d.nmi_pend = 1'b1;
    end
    // bus cycle definition
    r_d.ads = 1'b0;
    r_d.mgmt_address_strobe_n = 1'b0;
    r_d.wr_oe = !bus_float_in; // [R9]
    r_d.mgmt_address_strobe_n_oe = r_q.mgmt_en && !bus_float_in; // [R10]
    if (cyc_start_in) begin
      r_d.wr = cyc_write_in; // [R8] [R9]
      if (r_q.st == smsc_pkg::SMSC_SMM && r_q.mgmt_en) begin
        r_d.mgmt_address_strobe_n = 1'b1; // [R10]
      end else begin
        r_d.ads = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_q <= '{st: smsc_pkg::SMSC_RUN, mgmt_en: `SMSC_ENABLE_RST, default: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================
  // outputs
  assign system_mgmt_interrupt_n_out = 1'b0;
  assign system_mgmt_interrupt_n_oe_out = r_q.smi_drive; // [R3]
  assign suspend_ack_n_out = !r_q.suspend_request_n_ack; // [R7]
  assign suspend_ack_n_oe_out = 1'b1;
  assign exec_stall_out = (r_q.st != smsc_pkg::SMSC_RUN) && (r_q.st != smsc_pkg::SMSC_SMM);
  assign address_strobe_n_out = !r_q.ads;
  assign mgmt_address_strobe_n_out = !r_q.mgmt_address_strobe_n;
  assign mgmt_address_strobe_n_oe_out = r_q.mgmt_address_strobe_n_oe; // [R10]
  assign write_read_out = r_q.wr; // [R8] [R9]
  assign write_read_oe_out = r_q.wr_oe;

  // ==========================================
  // checks
  property p_smi_ignored;
    @(posedge core_clk_in) disable iff (rst_in)
      !r_q.mgmt_en |-> !smi_take_out;
  endproperty
  a_smi_ignored: assert property (p_smi_ignored) else $error("smi taken while disabled"); // [R4]

  property p_smi_first;
    @(posedge core_clk_in) disable iff (rst_in)
      smi_take_out |-> !nmi_take_out ##1 r_q.st == smsc_pkg::SMSC_SMM;
  endproperty
  a_smi_first: assert property (p_smi_first) else $error("nmi beat smi"); // [R2]

  property p_smi_drive;
    @(posedge core_clk_in) disable iff (rst_in)
      smi_take_out |=> system_mgmt_interrupt_n_oe_out until (r_q.st != smsc_pkg::SMSC_SMM);
  endproperty
  a_smi_drive: assert property (p_smi_drive) else $error("smi pin not held low"); // [R3]

  property p_smi_low4;
    @(posedge core_clk_in) disable iff (rst_in)
      smi_take_out |-> $past(!system_mgmt_interrupt_n_in, 4);
  endproperty
  a_smi_low4: assert property (p_smi_low4) else $error("smi taken too early"); // [R1]

  property p_drain;
    @(posedge core_clk_in) disable iff (rst_in)
      $rose(r_q.suspend_request_n_ack) |-> $past(coproc_busy_n_in) && $past(r_q.st) == smsc_pkg::SMSC_WAITCP;
  endproperty
  a_drain: assert property (p_drain) else $error("suspend entered early"); // [R5] [R6]

  property p_ack;
    @(posedge core_clk_in) disable iff (rst_in)
      (r_q.st == smsc_pkg::SMSC_SUSPEND_REQUEST_N) |-> !suspend_ack_n_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not low in suspend"); // [R7]

  property p_resume;
    @(posedge core_clk_in) disable iff (rst_in)
      (r_q.st == smsc_pkg::SMSC_SUSPEND_REQUEST_N && suspend_request_n_in && !halt_in)
        |=> suspend_ack_n_out && !exec_stall_out;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume"); // [R11]

  property p_wr;
    @(posedge core_clk_in) disable iff (rst_in)
      cyc_start_in |=> write_read_out == $past(cyc_write_in);
  endproperty
  a_wr: assert property (p_wr) else $error("write/read wrong"); // [R8] [R9]

  property p_strobe;
    @(posedge core_clk_in) disable iff (rst_in)
      cyc_start_in && r_q.st == smsc_pkg::SMSC_SMM && r_q.mgmt_en
        |=> !mgmt_address_strobe_n_out && address_strobe_n_out;
  endproperty
  a_strobe: assert property (p_strobe) else $error("wrong strobe in smm"); // [R10]

  c_smi: cover property (@(posedge core_clk_in) smi_take_out);
  c_suspend_request_n: cover property (@(posedge core_clk_in) r_q.st == smsc_pkg::SMSC_SUSPEND_REQUEST_N);
  c_nmi: cover property (@(posedge core_clk_in) nmi_take_out);
endmodule
`default_nettype wire

/* File: smsc_map.svh */
`ifndef SMSC_MAP_SVH
`define SMSC_MAP_SVH
// ==========================================
// timing counts
`define SMSC_SMI_LOW_CLKS 3'd4
// ==========================================
// reset values
`define SMSC_ENABLE_RST   1'b0
`endif

/* File: smsc_pkg.sv */
package smsc_pkg;
  typedef enum logic [2:0] {
    SMSC_RUN    = 3'b000,
    SMSC_DRAIN  = 3'b001,
    SMSC_WAITCP = 3'b010,
    SMSC_SUSPEND_REQUEST_N   = 3'b011,
    SMSC_SMM    = 3'b100
  } smsc_state_t;

  typedef struct packed {
    smsc_state_t st;
    logic        mgmt_en;
    logic        nmi_pend;
    logic        suspend_request_n_ack;
    logic        smi_drive;
    logic        wr;
    logic        wr_oe;
    logic        ads;
    logic        mgmt_address_strobe_n;
    logic        mgmt_address_strobe_n_oe;
  } smsc_regs_t;
endpackage

/* File: smsc_low_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "smsc_map.svh"
module smsc_low_filter #(
  parameter logic [2:0] COUNT = `SMSC_SMI_LOW_CLKS
) (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic level_n_in,
  output logic      seen_out
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  always_comb begin
    if (level_n_in) begin
      cnt_d = 3'h0;
    end else if (cnt_q < COUNT) begin
      cnt_d = cnt_q + 3'h1;
    end else begin
      cnt_d = cnt_q;
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // low for the whole count, sampled at the end
  assign seen_out = (cnt_q == COUNT);
endmodule
`default_nettype wire

/* File: smsc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module smsc_far_model (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  // bench commands
  input  wire logic       smi_go_in,
  input  wire logic       busy_go_in,
  input  wire logic [3:0] busy_len_in,
  // far side pins
  output logic            smi_low_out,
  output logic            coproc_busy_n_out
);
  // ====================
  // pin drivers
  logic [2:0] smi_cnt_q;
  logic [3:0] busy_cnt_q;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      smi_cnt_q  <= 3'h0;
      busy_cnt_q <= 4'h0;
    end else begin
      if (smi_go_in) begin
        smi_cnt_q <= 3'h5;
      end else if (smi_cnt_q != 3'h0) begin
        smi_cnt_q <= smi_cnt_q - 3'h1;
      end
      if (busy_go_in) begin
        busy_cnt_q <= busy_len_in;
      end else if (busy_cnt_q != 4'h0) begin
        busy_cnt_q <= busy_cnt_q - 4'h1;
      end
    end
  end
  assign smi_low_out       = (smi_cnt_q != 3'h0);
  assign coproc_busy_n_out = (busy_cnt_q == 4'h0);
endmodule
`default_nettype wire

/* File: test_smsc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module test_smsc_ctrl;
  // ====================
  // signals
  logic        clk, rst, cfg, en, nmi, ext, idle, hlt, sus_n, cs, cw, flt, sgo, bgo;
  logic [3:0]  blen;
  logic [31:0] r;
  int          num_errors, samples_checked, k, i;
  wire logic   s_oe, s_o, far_lo, bsy_n, n_tk, s_tk, ack_n, ack_oe, stl;
  wire logic   as_n, ms_n, ms_oe, wr, wr_oe;
  wire logic   smi_n = s_oe ? s_o : (far_lo ? 1'b0 : 1'b1);
  smsc_ctrl u_dut (.core_clk_in(clk), .rst_in(rst), .cfg_wr_in(cfg), .mgmt_enable_bit_in(en),
    .system_mgmt_interrupt_n_in(smi_n), .system_mgmt_interrupt_n_out(s_o),
    .system_mgmt_interrupt_n_oe_out(s_oe), .nmi_req_in(nmi), .nmi_take_out(n_tk),
    .smi_take_out(s_tk), .smm_exit_in(ext), .core_idle_in(idle), .halt_in(hlt),
    .coproc_busy_n_in(bsy_n), .suspend_request_n_in(sus_n), .suspend_ack_n_out(ack_n),
    .suspend_ack_n_oe_out(ack_oe), .exec_stall_out(stl), .cyc_start_in(cs),
    .cyc_write_in(cw), .bus_float_in(flt), .address_strobe_n_out(as_n),
    .mgmt_address_strobe_n_out(ms_n), .mgmt_address_strobe_n_oe_out(ms_oe),
    .write_read_out(wr), .write_read_oe_out(wr_oe));
  smsc_far_model u_far (.core_clk_in(clk), .rst_in(rst), .smi_go_in(sgo), .busy_go_in(bgo),
    .busy_len_in(blen), .smi_low_out(far_lo), .coproc_busy_n_out(bsy_n));
  // ====================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s exp %b got %b", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic bus(input logic w, input logic m);
    @(posedge clk) cs <= 1'b1;
    cw <= w;
    @(posedge clk) cs <= 1'b0;
    @(negedge clk);
    chk("wr", w, wr);
    chk("wr_oe", 1'b1, wr_oe);
    chk("as_n", m, as_n);
    chk("ms_n", !m, ms_n);
  endtask
  // ====================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst, cfg, en, nmi, ext, idle, hlt, cs, cw, flt, sgo, bgo} = 12'hfff & 12'h800;
    sus_n = 1'b1;
    blen = 4'h0;
    r = 32'h9124a29c;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("smi_oe", 1'b0, s_oe);
    chk("ack_n", 1'b1, ack_n);
    chk("ms_oe", 1'b0, ms_oe);
    @(posedge clk) sgo <= 1'b1;
    @(posedge clk) sgo <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(negedge clk) chk("smi_take", 1'b0, s_tk);
    end
    @(posedge clk) cfg <= 1'b1;
    en <= 1'b1;
    @(posedge clk) cfg <= 1'b0;
    sgo <= 1'b1;
    @(posedge clk) sgo <= 1'b0;
    repeat (3) @(posedge clk);
    nmi <= 1'b1;
    for (k = 0; k < 40 && s_tk !== 1'b1; k++) @(negedge clk);
    tmo(k);
    chk("nmi_take", 1'b0, n_tk);
    @(posedge clk) nmi <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(negedge clk) chk("smi_n", 1'b0, smi_n);
    end
    bus(1'b1, 1'b1);
    @(posedge clk) ext <= 1'b1;
    @(posedge clk) ext <= 1'b0;
    @(negedge clk) chk("smi_oe", 1'b0, s_oe);
    for (k = 0; k < 40 && n_tk !== 1'b1; k++) @(negedge clk);
    tmo(k);
    for (i = 0; i < 8; i++) begin
      r = lfsr(r);
      bus(r[0], 1'b0);
    end
    chk("ms_oe", 1'b1, ms_oe);
    @(posedge clk) flt <= 1'b1;
    @(negedge clk);
    @(negedge clk) chk("wr_oe", 1'b0, wr_oe);
    chk("ms_oe", 1'b0, ms_oe);
    @(posedge clk) flt <= 1'b0;
    sus_n <= 1'b0;
    for (i = 0; i < 6; i++) begin
      @(negedge clk) chk("ack_n", 1'b1, ack_n);
    end
    r = lfsr(r);
    @(posedge clk) bgo <= 1'b1;
    blen <= {2'h1, r[1:0]} + 4'h3;
    @(posedge clk) bgo <= 1'b0;
    idle <= 1'b1;
    repeat (3) @(negedge clk) chk("ack_n", 1'b1, ack_n);
    for (k = 0; k < 40 && ack_n !== 1'b0; k++) @(negedge clk);
    tmo(k);
    chk("busy_n", 1'b1, bsy_n);
    @(posedge clk) sus_n <= 1'b1;
    for (k = 0; k < 40 && ack_n !== 1'b1; k++) @(negedge clk);
    tmo(k);
    @(negedge clk) chk("stall", 1'b0, stl);
    @(posedge clk) hlt <= 1'b1;
    for (k = 0; k < 40 && ack_n !== 1'b0; k++) @(negedge clk);
    tmo(k);
    chk("ack_oe", 1'b1, ack_oe);
    @(posedge clk) hlt <= 1'b0;
    for (k = 0; k < 40 && ack_n !== 1'b1; k++) @(negedge clk);
    tmo(k);
    summarize();
  end
endmodule
`default_nettype wire
